// File: rtl/dma_band_consts.vh
/*
 * constants for the dma band control block: register offsets, field
 * positions, reset values and activation factor codes.
 * assumes an apb slave with byte addresses and 32-bit aligned words.
 */
`ifndef DMA_BAND_CONSTS_VH
`define DMA_BAND_CONSTS_VH

// ************************************************************
// register map
// ************************************************************
`define BAND_OFS        8'h00
`define CH_BASE_FIRST   4'h1
`define CH_BASE_LAST    4'h4
`define CH_MEM_OFS      4'h0
`define CH_IO_OFS       4'h4
`define CH_CNT_OFS      4'h8
`define CH_CTRL_OFS     4'hC

// ************************************************************
// band control fields
// ************************************************************
`define BAND_FAE_LSB    15'd14
`define BAND_ME_LSB     4'd12
`define BAND_TE_LSB     4'd8
`define BAND_EIE_LSB    4'd4
`define BAND_BIE_LSB    4'd2

// ************************************************************
// channel control fields
// ************************************************************
`define CTL_REPEAT      4'd0
`define CTL_DIR         4'd1
`define CTL_WORD        4'd2
`define CTL_DECR        4'd3
`define CTL_BURST       4'd4
`define CTL_AUTO        4'd5
`define CTL_BLOCK       4'd6
`define CTL_FACTOR_LSB  4'd8
`define CTL_MASK        16'h0F7F
`define CTL_RESET       16'h0000

// ************************************************************
// activation factors and address constants
// ************************************************************
`define FCT_CONV        4'h1
`define FCT_SER_TX      4'h4
`define FCT_SER_RX      4'h5
`define FCT_TMR0        4'h8
`define FCT_TMR1        4'h9
`define FCT_TMR2        4'hA
`define IO_UPPER        8'hFF
`define STEP_BYTE       24'h000001
`define STEP_WORD       24'h000002
`define CNT_ONE         16'h0001

`endif

// File: rtl/dma_band_ctrl.v
/*
 * dma enable and interrupt control with short address sequential and
 * idle modes, four channels, registers over apb.
 * assumes peripheral requests are one-cycle pulses on pclk and the
 * nmi pin is asynchronous.
 */
`timescale 1ns/100ps
`include "dma_band_consts.vh"

module dma_band_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire        nmi_pin,
	input  wire [5:0]  periph_req,
	output reg  [5:0]  periph_irq,
	output reg  [3:0]  end_irq,
	output reg  [1:0]  break_irq,
	output reg         xfer_strobe,
	output reg  [1:0]  xfer_channel,
	output reg  [23:0] xfer_src_addr,
	output reg  [23:0] xfer_dst_addr,
	output reg         xfer_word,
	output reg         bus_hold
);

// ************************************************************
// apb decode
// ************************************************************
wire        acc      = psel & penable;
wire        wr       = acc & pwrite;
wire        rd       = acc & ~pwrite;
wire        band_sel = (paddr == `BAND_OFS);
wire        ch_hit   = (paddr[7:4] >= `CH_BASE_FIRST) && (paddr[7:4] <= `CH_BASE_LAST) && (paddr[1:0] == 2'b00);
wire [1:0]  ch_idx   = paddr[5:4] - 2'd1;
wire [3:0]  ch_reg   = paddr[3:0];

// no wait states: every register answers in the access phase
assign pready = 1'b1;

// ************************************************************
// state
// ************************************************************
reg  [1:0]  fae_reg;
reg  [1:0]  me_reg;
reg  [3:0]  te_reg;
reg  [3:0]  eie_reg;
reg  [1:0]  bie_reg;
reg  [1:0]  me_arm_reg;
reg  [3:0]  te_arm_reg;
reg  [23:0] mem_reg  [0:3];
reg  [15:0] io_reg   [0:3];
reg  [15:0] cnt_reg  [0:3];
reg  [15:0] ctrl_reg [0:3];
reg  [3:0]  pend_reg;
reg  [3:0]  gap_reg;
reg         burst_reg;
reg  [1:0]  burst_ch_reg;
reg  [2:0]  nmi_sync_reg;
reg         nmi_level_reg;

reg  [1:0]  me_next;
reg  [3:0]  te_next;
reg  [1:0]  me_arm_next;
reg  [3:0]  te_arm_next;

wire [3:0]  run;
wire [3:0]  elig;
wire [3:0]  src_hit;
wire [3:0]  auto_ok;
wire [3:0]  done;
wire [5:0]  claim_vec [0:3];

// ************************************************************
// nmi pin: three stages, change counts once stages two and three agree
// ************************************************************
// the level only moves when two stages agree, so a glitch on the
// pin shorter than a clock never counts as an edge
wire nmi_agree = (nmi_sync_reg[1] == nmi_sync_reg[2]);
wire nmi_rise  = nmi_agree & nmi_sync_reg[2] & ~nmi_level_reg;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		nmi_sync_reg  <= 3'b000;
		nmi_level_reg <= 1'b0;
	end else begin
		nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
		if (nmi_agree)
			nmi_level_reg <= nmi_sync_reg[2];
	end
end

// ************************************************************
// per channel qualification
// ************************************************************
function [2:0] factor_index;
	input [3:0] f;
	begin
		case (f)
			`FCT_CONV:   factor_index = 3'd0;
			`FCT_SER_TX: factor_index = 3'd1;
			`FCT_SER_RX: factor_index = 3'd2;
			`FCT_TMR0:   factor_index = 3'd3;
			`FCT_TMR1:   factor_index = 3'd4;
			`FCT_TMR2:   factor_index = 3'd5;
			default:     factor_index = 3'd7;
		endcase
	end
endfunction

// grant: an owned burst keeps the bus, else lowest channel wins
reg         gnt_valid;
reg  [1:0]  gnt_ch;
integer     k;

always @* begin
	gnt_valid = 1'b0;
	gnt_ch    = 2'd0;
	if (burst_reg && elig[burst_ch_reg]) begin
		gnt_valid = 1'b1;
		gnt_ch    = burst_ch_reg;
	end else begin
		for (k = 3; k >= 0; k = k - 1) begin
			if (elig[k]) begin
				gnt_valid = 1'b1;
				gnt_ch    = k[1:0];
			end
		end
	end
end

genvar c;
generate
	for (c = 0; c < 4; c = c + 1) begin : g_ch
		wire [2:0]  fidx   = factor_index(ctrl_reg[c][11:8]);
		wire        pair_full = fae_reg[c/2];
		wire        is_b   = (c % 2) == 1;
		wire        idle   = ctrl_reg[c][`CTL_REPEAT] & eie_reg[c];
		wire        granted = gnt_valid && (gnt_ch == c);
		wire [23:0] step   = ctrl_reg[c][`CTL_WORD] ? `STEP_WORD : `STEP_BYTE;
		wire        sw_sel = wr && ch_hit && (ch_idx == c);

		assign run[c]     = me_reg[c/2] & te_reg[c] & ~(pair_full & is_b);
		assign src_hit[c] = (fidx != 3'd7) && periph_req[fidx];
		assign auto_ok[c] = pair_full & ctrl_reg[c][`CTL_AUTO];
		assign elig[c]    = run[c] & (auto_ok[c] ? ~gap_reg[c] : pend_reg[c]);
		assign done[c]    = granted && (cnt_reg[c] == `CNT_ONE);
		assign claim_vec[c] = (te_reg[c] && fidx != 3'd7) ? (6'h01 << fidx) : 6'h00;

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem_reg[c]  <= 24'h000000;
				io_reg[c]   <= 16'h0000;
				cnt_reg[c]  <= 16'h0000;
				ctrl_reg[c] <= `CTL_RESET;
				pend_reg[c] <= 1'b0;
				gap_reg[c]  <= 1'b0;
			end else begin
				// set wins over the grant that clears it
				pend_reg[c] <= run[c] & (src_hit[c] | (pend_reg[c] & ~granted));
				gap_reg[c]  <= granted & ~ctrl_reg[c][`CTL_BURST];
				if (sw_sel && ch_reg == `CH_MEM_OFS)
					mem_reg[c] <= pwdata[23:0];
				else if (granted && !idle) begin
					if (ctrl_reg[c][`CTL_DECR])
						mem_reg[c] <= mem_reg[c] - step;
					else
						mem_reg[c] <= mem_reg[c] + step;
				end
				if (sw_sel && ch_reg == `CH_IO_OFS)
					io_reg[c] <= pwdata[15:0];
				// zero wraps to ffff, giving 65536 transfers
				if (sw_sel && ch_reg == `CH_CNT_OFS)
					cnt_reg[c] <= pwdata[15:0];
				else if (granted)
					cnt_reg[c] <= cnt_reg[c] - `CNT_ONE;
				if (sw_sel && ch_reg == `CH_CTRL_OFS)
					ctrl_reg[c] <= pwdata[15:0] & `CTL_MASK;
			end
		end
	end
endgenerate

// ************************************************************
// end request
// ************************************************************
// a plain level: software cancels it through the enables only,
// so nothing here needs to remember that a count ran out
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		end_irq <= 4'b0000;
	else
		end_irq <= eie_reg & ~te_reg;
end

// ************************************************************
// enable bits: read-as-zero arming, software writes, hardware clears
// ************************************************************
wire [23:0] g_mem  = mem_reg[gnt_ch];
wire [23:0] g_io   = {`IO_UPPER, io_reg[gnt_ch]};
wire [15:0] g_ctrl = ctrl_reg[gnt_ch];
// a block-mode channel ignores nmi entirely: no clear, no suspend
wire        nmi_hit = nmi_rise & burst_reg & ~ctrl_reg[burst_ch_reg][`CTL_BLOCK];
wire        nmi_pair = burst_ch_reg[1];
integer     b;

always @* begin
	me_next     = me_reg;
	te_next     = te_reg;
	me_arm_next = me_arm_reg;
	te_arm_next = te_arm_reg;
	if (rd && band_sel) begin
		me_arm_next = ~me_reg;
		te_arm_next = ~te_reg;
	end
	if (wr && band_sel) begin
		me_arm_next = 2'b00;
		te_arm_next = 4'b0000;
		for (b = 0; b < 2; b = b + 1) begin
			if (!pwdata[12 + b])
				me_next[b] = 1'b0;
			else if (me_arm_reg[b])
				me_next[b] = 1'b1;
		end
		for (b = 0; b < 4; b = b + 1) begin
			if (!pwdata[8 + b])
				te_next[b] = 1'b0;
			else if (te_arm_reg[b])
				te_next[b] = 1'b1;
		end
	end
	// the channel's own state is kept, so a later re-enable resumes it
	if (nmi_hit)
		me_next[nmi_pair] = 1'b0;
	te_next = te_next & ~done;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fae_reg      <= 2'b00;
		me_reg       <= 2'b00;
		te_reg       <= 4'b0000;
		eie_reg      <= 4'b0000;
		bie_reg      <= 2'b00;
		me_arm_reg   <= 2'b00;
		te_arm_reg   <= 4'b0000;
		burst_reg    <= 1'b0;
		burst_ch_reg <= 2'd0;
		break_irq    <= 2'b00;
		periph_irq   <= 6'h00;
		bus_hold     <= 1'b0;
	end else begin
		me_reg     <= me_next;
		te_reg     <= te_next;
		me_arm_reg <= me_arm_next;
		te_arm_reg <= te_arm_next;
		if (wr && band_sel) begin
			fae_reg <= pwdata[15:14];
			eie_reg <= pwdata[7:4];
			bie_reg <= pwdata[3:2];
		end
		if (nmi_hit)
			burst_reg <= 1'b0;
		else if (gnt_valid) begin
			burst_reg    <= auto_ok[gnt_ch] & g_ctrl[`CTL_BURST] & ~done[gnt_ch];
			burst_ch_reg <= gnt_ch;
		end else if (burst_reg && !run[burst_ch_reg])
			burst_reg <= 1'b0;
		bus_hold   <= (gnt_valid & auto_ok[gnt_ch] & g_ctrl[`CTL_BURST] & ~done[gnt_ch]) & ~nmi_hit;
		break_irq  <= bie_reg & ~me_reg;
		periph_irq <= periph_req & ~(claim_vec[0] | claim_vec[1] | claim_vec[2] | claim_vec[3]);
	end
end

// ************************************************************
// transfer strobe
// ************************************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		xfer_strobe   <= 1'b0;
		xfer_channel  <= 2'd0;
		xfer_src_addr <= 24'h000000;
		xfer_dst_addr <= 24'h000000;
		xfer_word     <= 1'b0;
	end else begin
		xfer_strobe <= gnt_valid;
		if (gnt_valid) begin
			xfer_channel  <= gnt_ch;
			xfer_word     <= g_ctrl[`CTL_WORD];
			xfer_src_addr <= g_ctrl[`CTL_DIR] ? g_io : g_mem;
			xfer_dst_addr <= g_ctrl[`CTL_DIR] ? g_mem : g_io;
		end
	end
end

// ************************************************************
// apb read and error
// ************************************************************
// band word: [15:14] full mode, [13:12] master, [11:8] transfer,
// [7:4] end enables, [3:2] break enables, [1:0] read as zero
wire [31:0] band_word = {16'h0000, fae_reg, me_reg, te_reg, eie_reg, bie_reg, 2'b00};

// reads are side-effect free except the arming above
always @* begin
	prdata  = 32'h00000000;
	pslverr = 1'b0;
	if (acc) begin
		if (band_sel)
			prdata = band_word;
		else if (ch_hit) begin
			case (ch_reg)
				`CH_MEM_OFS:  prdata = {8'h00, mem_reg[ch_idx]};
				`CH_IO_OFS:   prdata = {16'h0000, io_reg[ch_idx]};
				`CH_CNT_OFS:  prdata = {16'h0000, cnt_reg[ch_idx]};
				`CH_CTRL_OFS: prdata = {16'h0000, ctrl_reg[ch_idx]};
				default:      prdata = 32'h00000000;
			endcase
		end else
			pslverr = 1'b1;
	end
end

endmodule // dma_band_ctrl

// File: sim/dma_band_ctrl_checker.sv
/* port checker for dma_band_ctrl: interrupt causes, request hand-off, nmi release
   assumes one clock and the async active-low reset of the top module */
`timescale 1ns/100ps
module dma_band_ctrl_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire        nmi_pin,
	input wire [5:0]  periph_req,
	input wire [5:0]  periph_irq,
	input wire [3:0]  end_irq,
	input wire [1:0]  break_irq,
	input wire        xfer_strobe,
	input wire [23:0] xfer_src_addr,
	input wire [23:0] xfer_dst_addr,
	input wire        bus_hold
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire      acc = psel && penable && pwrite;
	reg [3:0] nmi_age;
	// saturates, so an old nmi never excuses a break request
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			nmi_age <= 4'hF;
		else if ($rose(nmi_pin))
			nmi_age <= 4'h0;
		else if (nmi_age != 4'hF)
			nmi_age <= nmi_age + 4'h1;
	sequence nmi_in_burst;
		$rose(nmi_pin) && bus_hold;
	endsequence
	sequence req_then_stb;
		periph_req != 6'h00 ##2 xfer_strobe;
	endsequence
	a_irq_from_req: assert property ((periph_irq & ~$past(periph_req)) == 6'h00)
		else $error("irq without request");
	a_req_answered: assert property (periph_req != 6'h00 |=> periph_irq != 6'h00 or ##[0:3] xfer_strobe)
		else $error("request lost");
	a_taken_not_passed: assert property (req_then_stb |->
		($past(periph_irq) & $past(periph_req, 2)) == 6'h00) else $error("taken request passed on");
	a_io_upper_ones: assert property (req_then_stb |->
		xfer_src_addr[23:16] == 8'hFF || xfer_dst_addr[23:16] == 8'hFF) else $error("io upper byte");
	a_end_has_cause: assert property ((end_irq & ~$past(end_irq)) != 4'h0 |->
		$past(xfer_strobe) || $past(xfer_strobe, 2) || $past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("end irq without cause");
	a_break_has_cause: assert property ((break_irq & ~$past(break_irq)) != 2'h0 |->
		$past(acc) || $past(acc, 2) || $past(acc, 3) || nmi_age < 4'hC) else $error("break irq without cause");
	a_nmi_frees_bus: assert property (nmi_in_burst |-> ##[2:8] !bus_hold) else $error("bus kept after nmi");
	a_hold_stays_off: assert property (nmi_in_burst ##[2:8] !bus_hold |=> !bus_hold [*3])
		else $error("burst resumed unasked");
endmodule // dma_band_ctrl_checker
bind dma_band_ctrl dma_band_ctrl_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .nmi_pin(nmi_pin), .periph_req(periph_req), .periph_irq(periph_irq), .end_irq(end_irq),
	.break_irq(break_irq), .xfer_strobe(xfer_strobe), .xfer_src_addr(xfer_src_addr),
	.xfer_dst_addr(xfer_dst_addr), .bus_hold(bus_hold));

// File: sim/periph_src_model.sv
/* peripheral interrupt flags and nmi pin facing dma_band_ctrl
   assumes callers enter its tasks just after a clock edge */
`timescale 1ns/100ps
module periph_src_model (
	input  wire        pclk,
	output logic [5:0] periph_req,
	output logic       nmi_pin
);
	initial begin
		periph_req = 6'h00;
		nmi_pin = 1'b0;
	end
	// one-cycle flag; a longer one would ask twice
	task pulse(input int k);
		@(posedge pclk) periph_req <= 6'h01 << k;
		@(posedge pclk) periph_req <= 6'h00;
	endtask
	// held long enough for the synchroniser
	task nmi();
		@(posedge pclk) nmi_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		nmi_pin <= 1'b0;
	endtask
endmodule // periph_src_model

// File: sim/dma_band_ctrl_tb.sv
/* self-checking bench for dma_band_ctrl: apb tasks, row-driven transfers, hand cases
   assumes periph_src_model as the peripherals and the bound checker */
`timescale 1ns/100ps
module dma_band_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        xfer_strobe, xfer_word, bus_hold, nmi_pin, rep, dcr, wd, dir;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, rdat;
	logic [5:0]  periph_req, periph_irq;
	logic [3:0]  end_irq, fct [6];
	logic [2:0]  rq;
	logic [1:0]  break_irq, xfer_channel, ch;
	logic [23:0] xfer_src_addr, xfer_dst_addr, m;
	logic [8:0]  rows [6];
	int          n_mismatch, n_tests, nstb, k, st;
	dma_band_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nmi_pin(nmi_pin), .periph_req(periph_req), .periph_irq(periph_irq), .end_irq(end_irq),
		.break_irq(break_irq), .xfer_strobe(xfer_strobe), .xfer_channel(xfer_channel),
		.xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr), .xfer_word(xfer_word),
		.bus_hold(bus_hold));
	periph_src_model src (.pclk(pclk), .periph_req(periph_req), .nmi_pin(nmi_pin));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// non-blocking, so reads at an edge never race the count
	always @(posedge pclk)
		if (xfer_strobe === 1'b1)
			nstb <= nstb + 1;
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_stb();
		@(posedge pclk);
		while (xfer_strobe !== 1'b1)
			@(posedge pclk);
	endtask
	task tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		tally_and_finish();
	end
	// ************************************************************
	// tests: rows {channel, source, repeat, decrement, word, direction}
	// ************************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{n_mismatch, n_tests, nstb} = '0;
		fct = '{4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA};
		rows = '{9'h000, 9'h097, 9'h129, 9'h1B2, 9'h04A, 9'h0D4};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wr(8'h00, 32'h1100);
		rd(8'h00);
		chk(rdat, 32'h0);
		rd(8'hF0);
		chk(err, 1'b1);
		for (int i = 0; i < 6; i++) begin
			{ch, rq, rep, dcr, wd, dir} = rows[i];
			b = 8'h10 * (ch + 2'h1);
			st = rep ? 0 : (wd ? 2 : 1);
			st = dcr ? -st : st;
			wr(b, 32'h1000);
			wr(b + 8'h04, 32'h1234);
			wr(b + 8'h08, 32'h2);
			wr(b + 8'h0C, {20'h0, fct[rq], 4'h0, dcr, wd, dir, rep});
			rd(8'h00);
			wr(8'h00, (32'h1000 << ch[1]) | (32'h110 << ch));
			for (k = 0; k < 2; k++) begin
				src.pulse(rq);
				wait_stb();
				m = 24'h001000 + 24'(k * st);
				chk(xfer_channel, ch);
				chk(xfer_word, wd);
				chk(xfer_src_addr, dir ? 24'hFF1234 : m);
				chk(xfer_dst_addr, dir ? m : 24'hFF1234);
			end
			repeat (3) @(posedge pclk);
			chk(end_irq[ch], 1'b1);
			rd(8'h00);
			chk(rdat[8 + ch], 1'b0);
			wr(8'h00, 32'h0);
		end
		src.pulse(0);
		k = nstb;
		@(negedge pclk);
		chk(periph_irq, 6'h01);
		repeat (3) @(posedge pclk);
		chk(nstb, k);
		wr(8'h00, 32'h10);
		repeat (2) @(posedge pclk);
		chk(end_irq, 4'h1);
		wr(8'h00, 32'h0);
		repeat (2) @(posedge pclk);
		chk(end_irq, 4'h0);
		wr(8'h00, 32'h4);
		repeat (2) @(posedge pclk);
		chk(break_irq, 2'h1);
		rd(8'h00);
		wr(8'h00, 32'h1004);
		repeat (2) @(posedge pclk);
		chk(break_irq, 2'h0);
		wr(8'h18, 32'h0);
		wr(8'h1C, 32'h100);
		rd(8'h00);
		wr(8'h00, 32'h1100);
		src.pulse(0);
		wait_stb();
		rd(8'h18);
		chk(rdat, 32'hFFFF);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h28);
		wr(8'h1C, 32'h30);
		st = nstb;
		rd(8'h00);
		wr(8'h00, 32'h5100);
		while (bus_hold !== 1'b1)
			@(posedge pclk);
		src.nmi();
		repeat (10) @(posedge pclk);
		k = nstb;
		chk(bus_hold, 1'b0);
		rd(8'h00);
		chk(rdat[12], 1'b0);
		chk(nstb, k);
		chk(k - st < 40, 1'b1);
		wr(8'h00, 32'h5100);
		while (rdat[8] !== 1'b0)
			rd(8'h00);
		chk(nstb - st, 40);
		tally_and_finish();
	end
endmodule // dma_band_ctrl_tb
